// ### adcr_pkg.sv
package adcr_pkg;
  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [11:0] REF_SEL_OFFS    = 12'h000;
  localparam logic [11:0] FMT_TIM_OFFS    = 12'h004;
  localparam logic [11:0] CONV_CTRL_OFFS  = 12'h008;
  localparam logic [11:0] RESULT_LO_OFFS  = 12'h00c;
  localparam logic [11:0] RESULT_HI_OFFS  = 12'h010;
  // ==========================================================
  // Field positions
  localparam int NEG_REF_LSB   = 0;
  localparam int POS_REF_LSB   = 2;
  localparam int CLK_SEL_LSB   = 0;
  localparam int ACQ_SEL_LSB   = 3;
  localparam int JUSTIFY_BIT   = 7;
  localparam int START_BIT     = 1;
  // ==========================================================
  // Reset values and write masks
  localparam logic [7:0] REF_SEL_RST   = 8'h00;
  localparam logic [7:0] FMT_TIM_RST   = 8'h00;
  localparam logic [7:0] REF_SEL_MASK  = 8'h0f;
  localparam logic [7:0] FMT_TIM_MASK  = 8'hbf;
  // ==========================================================
  // Codes
  localparam logic [2:0] CLK_DEDICATED_A = 3'h3;
  localparam logic [2:0] CLK_DEDICATED_B = 3'h7;
  // Conversion time in conversion-clock periods (10 bits plus sample)
  localparam logic [4:0] CONV_PERIODS    = 5'h0b;
  // Instruction cycle as system clock cycles
  localparam logic [3:0] INSTR_CYCLES    = 4'h4;
  // Dedicated oscillator period in system clocks: 1/600 kHz at 125 MHz
  localparam int FRC_KHZ  = 600;
  localparam int CLK_KHZ  = 125000;
  localparam int FRC_DIV  = CLK_KHZ / FRC_KHZ;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HOLD = 4'b0010,
    ST_ACQ  = 4'b0100,
    ST_CONV = 4'b1000
  } adcr_state_t;
endpackage : adcr_pkg

// ### adcr_tick.sv
`timescale 1ns/1ps
// Conversion-clock tick generator: one pulse per conversion-clock period
module adcr_tick #(
  parameter int CNT_W = 8
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       clkEn,
  input  wire logic       run,
  input  wire logic [2:0] clockSel,
  output logic            tick
);
  import adcr_pkg::*;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;
  // The dedicated-oscillator period needs eight bits; a narrower counter would wrap early
  if (CNT_W < 8 || CNT_W > 16) begin : g_bad_width
    $error("tick counter width out of range");
  end
  // ==========================================================
  // Period per select code; dedicated oscillator approximated by a divider
  always_comb begin
    case (clockSel)
      3'h0:    limit = CNT_W'(8'h01);
      3'h1:    limit = CNT_W'(8'h07);
      3'h2:    limit = CNT_W'(8'h1f);
      3'h4:    limit = CNT_W'(8'h03);
      3'h5:    limit = CNT_W'(8'h0f);
      3'h6:    limit = CNT_W'(8'h3f);
      default: limit = CNT_W'(FRC_DIV - 1);
    endcase
  end
  // Counter restarts whenever the block is idle so the first period is whole
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (clkEn) begin
      if (!run || cnt_q == limit) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end
  assign tick = run && clkEn && (cnt_q == limit);
endmodule : adcr_tick

// ### adcr_top.sv
`timescale 1ns/1ps
// What this block does
// - Acquisition delay code 000 none, else 2,4,6,8,12,16,20 conversion-clock periods.
// - With dedicated oscillator, conversion start waits one instruction cycle.
// - Format bit 7 set means right justified, clear means left justified.
// - Positive reference field bits 3-2: supply, pin, fixed reference, reserved.
// - Negative reference field bits 1-0: ground, pin, others reserved.
// - All fields reset to zero; unimplemented bits read zero and ignore writes.
// - Start flag set by software stays high until conversion completes.
// - Right justified: low eight bits low register, top two in high register.
module adcr_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [9:0]  sampleData,
  output logic [1:0]       posRefSel,
  output logic [1:0]       negRefSel,
  output logic             sampling,
  output logic             converting
);
  import adcr_pkg::*;

  logic [7:0]  refSel_q;
  logic [7:0]  fmtTim_q;
  logic        start_q;
  logic [2:0]  acqHeld_q;
  logic [2:0]  clkHeld_q;
  logic [4:0]  cnt_q;
  logic [3:0]  hold_q;
  logic [9:0]  result_q;
  logic [7:0]  resLo;
  logic [7:0]  resHi;
  logic        tick;
  logic        wrEn;
  logic        rdHit;
  logic        startReq;
  logic        done;
  adcr_state_t state_q;

  // ==========================================================
  // Acquisition delay decode
  function automatic logic [4:0] acq_periods(input logic [2:0] code);
    case (code)
      3'h0:    acq_periods = 5'd0;
      3'h1:    acq_periods = 5'd2;
      3'h2:    acq_periods = 5'd4;
      3'h3:    acq_periods = 5'd6;
      3'h4:    acq_periods = 5'd8;
      3'h5:    acq_periods = 5'd12;
      3'h6:    acq_periods = 5'd16;
      default: acq_periods = 5'd20;
    endcase
  endfunction : acq_periods

  function automatic logic is_dedicated(input logic [2:0] code);
    is_dedicated = (code == CLK_DEDICATED_A) || (code == CLK_DEDICATED_B);
  endfunction : is_dedicated

  // ==========================================================
  // APB slave: zero wait states, error on unmapped addresses
  assign pready   = 1'b1;
  assign wrEn     = psel && penable && pwrite && clkEn;
  assign rdHit    = (paddr == REF_SEL_OFFS) || (paddr == FMT_TIM_OFFS) || (paddr == CONV_CTRL_OFFS) ||
                    (paddr == RESULT_LO_OFFS) || (paddr == RESULT_HI_OFFS);
  assign pslverr  = psel && penable && !rdHit;
  assign startReq = wrEn && (paddr == CONV_CTRL_OFFS) && pwdata[START_BIT] && state_q == ST_IDLE;

  // Configuration registers; masked so unused bits stay zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      refSel_q <= REF_SEL_RST;
      fmtTim_q <= FMT_TIM_RST;
    end else if (wrEn) begin
      if (paddr == REF_SEL_OFFS) begin
        refSel_q <= pwdata[7:0] & REF_SEL_MASK;
      end
      if (paddr == FMT_TIM_OFFS) begin
        fmtTim_q <= pwdata[7:0] & FMT_TIM_MASK;
      end
    end
  end

  // Read mux; result registers follow the current format bit
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      REF_SEL_OFFS:   prdata[7:0] = refSel_q;
      FMT_TIM_OFFS:   prdata[7:0] = fmtTim_q;
      CONV_CTRL_OFFS: prdata[START_BIT] = start_q;
      RESULT_LO_OFFS: prdata[7:0] = resLo;
      RESULT_HI_OFFS: prdata[7:0] = resHi;
      default:        prdata = 32'h0000_0000;
    endcase
  end

  // Justification of the held result
  always_comb begin
    if (fmtTim_q[JUSTIFY_BIT]) begin
      resLo = result_q[7:0];
      resHi = {6'h00, result_q[9:8]};
    end else begin
      resLo = {result_q[1:0], 6'h00};
      resHi = result_q[9:2];
    end
  end

  // Reference selects drive the analog muxes directly
  assign posRefSel = refSel_q[POS_REF_LSB +: 2];
  assign negRefSel = refSel_q[NEG_REF_LSB +: 2];

  // ==========================================================
  // Conversion sequencer
  adcr_tick #(.CNT_W(8)) adcr_tick_inst (
    .clk      (clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .run      (state_q == ST_ACQ || state_q == ST_CONV),
    .clockSel (clkHeld_q),
    .tick     (tick)
  );

  assign done = state_q == ST_CONV && tick && cnt_q == CONV_PERIODS - 5'd1;

  // Timing fields captured only at start so mid-conversion writes cannot glitch timing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acqHeld_q <= 3'h0;
      clkHeld_q <= 3'h0;
    end else if (startReq) begin
      acqHeld_q <= fmtTim_q[ACQ_SEL_LSB +: 3];
      clkHeld_q <= fmtTim_q[CLK_SEL_LSB +: 3];
    end
  end

  // Start flag: set by software, cleared by hardware at completion only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_q <= 1'b0;
    end else if (clkEn) begin
      if (startReq) begin
        start_q <= 1'b1;
      end else if (done) begin
        start_q <= 1'b0;
      end
    end
  end

  // State machine: hold (dedicated clock), acquisition, conversion
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'd0;
      hold_q  <= 4'h0;
    end else if (clkEn) begin
      case (state_q)
        ST_IDLE: begin
          cnt_q  <= 5'd0;
          hold_q <= 4'h0;
          if (startReq) begin
            if (is_dedicated(fmtTim_q[CLK_SEL_LSB +: 3])) begin
              state_q <= ST_HOLD;
            end else if (fmtTim_q[ACQ_SEL_LSB +: 3] == 3'h0) begin
              state_q <= ST_CONV;
            end else begin
              state_q <= ST_ACQ;
            end
          end
        end
        ST_HOLD: begin
          hold_q <= hold_q + 4'h1;
          if (hold_q == INSTR_CYCLES - 4'h1) begin
            state_q <= (acqHeld_q == 3'h0) ? ST_CONV : ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (tick) begin
            if (cnt_q == acq_periods(acqHeld_q) - 5'd1) begin
              cnt_q   <= 5'd0;
              state_q <= ST_CONV;
            end else begin
              cnt_q <= cnt_q + 5'd1;
            end
          end
        end
        ST_CONV: begin
          if (tick) begin
            if (done) begin
              state_q <= ST_IDLE;
              cnt_q   <= 5'd0;
            end else begin
              cnt_q <= cnt_q + 5'd1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Result captured at completion; unknown data is not a concern since reset clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_q <= 10'h000;
    end else if (clkEn && done) begin
      result_q <= sampleData;
    end
  end

  assign sampling   = state_q == ST_ACQ;
  assign converting = state_q == ST_CONV;

  // ==========================================================
  // Checks
  property p_flag_busy;
    @(posedge clk) disable iff (!resetn)
      (state_q != ST_IDLE) |-> start_q;
  endproperty
  a_flag_busy: assert property (p_flag_busy) else $error("start flag low during conversion");

  property p_flag_clears;
    @(posedge clk) disable iff (!resetn)
      (clkEn && done) |=> !start_q && state_q == ST_IDLE;
  endproperty
  a_flag_clears: assert property (p_flag_clears) else $error("start flag not cleared at done");

  property p_dedicated_hold;
    @(posedge clk) disable iff (!resetn)
      (startReq && is_dedicated(fmtTim_q[2:0])) |=> state_q == ST_HOLD;
  endproperty
  a_dedicated_hold: assert property (p_dedicated_hold) else $error("dedicated clock start not delayed");

  property p_no_delay;
    @(posedge clk) disable iff (!resetn)
      (startReq && !is_dedicated(fmtTim_q[2:0]) && fmtTim_q[5:3] == 3'h0) |=> state_q == ST_CONV;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("zero delay code did not skip acquisition");

  property p_held_stable;
    @(posedge clk) disable iff (!resetn)
      (state_q != ST_IDLE && $past(state_q) != ST_IDLE) |-> $stable(clkHeld_q) && $stable(acqHeld_q);
  endproperty
  a_held_stable: assert property (p_held_stable) else $error("timing fields changed mid conversion");

  property p_unused_zero;
    @(posedge clk) disable iff (!resetn)
      refSel_q[7:4] == 4'h0 && fmtTim_q[6] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unimplemented bit set");

  property p_right_just;
    @(posedge clk) disable iff (!resetn)
      fmtTim_q[JUSTIFY_BIT] |-> resHi[7:2] == 6'h00 && {resHi[1:0], resLo} == result_q;
  endproperty
  a_right_just: assert property (p_right_just) else $error("right justified layout wrong");

  property p_left_just;
    @(posedge clk) disable iff (!resetn)
      !fmtTim_q[JUSTIFY_BIT] |-> {resHi, resLo[7:6]} == result_q && resLo[5:0] == 6'h00;
  endproperty
  a_left_just: assert property (p_left_just) else $error("left justified layout wrong");

  property p_pos_ref;
    @(posedge clk) disable iff (!resetn)
      posRefSel == refSel_q[3:2] && negRefSel == refSel_q[1:0];
  endproperty
  a_pos_ref: assert property (p_pos_ref) else $error("reference select mismatch");

endmodule : adcr_top

// ### adcr_top_tb.sv
`timescale 1ns/1ps
module adcr_top_tb;
  import adcr_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clkEn = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  sampleData = 10'h000;
  logic [1:0]  posRefSel;
  logic [1:0]  negRefSel;
  logic        sampling;
  logic        converting;
  logic [31:0] seed = 32'h7ff9543c;
  int          errCount = 0;
  int          checks = 0;
  int          sampTot = 0;
  int          convTot = 0;
  adcr_top adcr_top_inst (.clk(clk), .resetn(resetn), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleData(sampleData), .posRefSel(posRefSel), .negRefSel(negRefSel), .sampling(sampling),
    .converting(converting));
  // ==========================================================
  // Clock and activity counters
  initial begin
    forever #4 clk = ~clk;
  end
  // Totals only grow, so a test takes differences and never races a clear
  always @(posedge clk) begin
    if (sampling === 1'b1) sampTot <= sampTot + 1;
    if (converting === 1'b1) convTot <= convTot + 1;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic int acqP(input logic [2:0] c);
    case (c)
      3'h0: return 0;
      3'h1: return 2;
      3'h2: return 4;
      3'h3: return 6;
      3'h4: return 8;
      3'h5: return 12;
      3'h6: return 16;
      default: return 20;
    endcase
  endfunction : acqP
  function automatic int divOf(input logic [2:0] c);
    case (c)
      3'h0: return 2;
      3'h1: return 8;
      3'h2: return 32;
      3'h4: return 4;
      3'h5: return 16;
      3'h6: return 64;
      default: return FRC_DIV;
    endcase
  endfunction : divOf
  function automatic logic [31:0] expRes(input logic [9:0] d, input logic rj, input logic hi);
    if (rj) return hi ? {30'h0, d[9:8]} : {24'h0, d[7:0]};
    return hi ? {24'h0, d[9:2]} : {24'h0, d[1:0], 6'h00};
  endfunction : expRes
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      errCount++;
    end
  endtask : chk
  task automatic chkRange(input string name, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
      errCount++;
    end
  endtask : chkRange
  // One APB transfer; the request holds until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : completeRun
  // Watchdog: the whole run needs about 13000 cycles, so 50000 means a hang
  initial begin
    #400000;
    errCount++;
    completeRun();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r, v, fmt;
    logic        e;
    logic        ded;
    int          s0, c0, n, dv;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    apb(1'b0, REF_SEL_OFFS, 32'h0, r, e);
    chk("ref reset", 32'h0, r);
    chk("mapped err", 32'h0, {31'h0, e});
    apb(1'b0, FMT_TIM_OFFS, 32'h0, r, e);
    chk("fmt reset", 32'h0, r);
    apb(1'b0, CONV_CTRL_OFFS, 32'h0, r, e);
    chk("start reset", 32'h0, r);
    $display("test reset values done");
    for (int k = 0; k < 16; k++) begin
      v = xs();
      v[3:0] = k[3:0];
      apb(1'b1, REF_SEL_OFFS, v, r, e);
      apb(1'b0, REF_SEL_OFFS, 32'h0, r, e);
      chk("ref readback", {24'h0, v[7:0] & REF_SEL_MASK}, r);
      chk("posRefSel", {30'h0, v[3:2]}, {30'h0, posRefSel});
      chk("negRefSel", {30'h0, v[1:0]}, {30'h0, negRefSel});
      v = xs();
      apb(1'b1, FMT_TIM_OFFS, v, r, e);
      apb(1'b0, FMT_TIM_OFFS, 32'h0, r, e);
      chk("fmt readback", {24'h0, v[7:0] & FMT_TIM_MASK}, r);
    end
    // Writes while the clock enable is low are lost
    apb(1'b1, REF_SEL_OFFS, 32'h9, r, e);
    clkEn <= 1'b0;
    apb(1'b1, REF_SEL_OFFS, 32'h6, r, e);
    clkEn <= 1'b1;
    apb(1'b0, REF_SEL_OFFS, 32'h0, r, e);
    chk("ref clkEn low", 32'h9, r);
    apb(1'b1, 12'h014, xs(), r, e);
    chk("unmapped wr err", 32'h1, {31'h0, e});
    apb(1'b0, 12'h014, 32'h0, r, e);
    chk("unmapped rd", 32'h0, r);
    chk("unmapped rd err", 32'h1, {31'h0, e});
    $display("test registers done");
    // Every acquisition code and every clock code, with fields changed mid-run
    for (int i = 0; i < 8; i++) begin
      fmt = {24'h0, i[0], 1'b0, i[2:0], i[2:0]};
      dv = divOf(i[2:0]);
      ded = (i[1:0] == 2'h3);
      apb(1'b1, FMT_TIM_OFFS, fmt, r, e);
      v = xs();
      sampleData <= v[9:0];
      s0 = sampTot;
      c0 = convTot;
      apb(1'b1, CONV_CTRL_OFFS, 32'h2, r, e);
      chk("busy after start", {31'h0, !ded}, {31'h0, sampling | converting});
      // Dedicated clock: four idle cycles before acquisition begins
      if (ded) begin
        repeat (3) @(posedge clk);
        chk("hold before acq", 32'h0, {31'h0, sampling | converting});
        @(posedge clk);
        chk("acq after hold", 32'h1, {31'h0, sampling});
      end
      apb(1'b0, CONV_CTRL_OFFS, 32'h0, r, e);
      chk("start high", 32'h1, {31'h0, r[START_BIT]});
      apb(1'b1, FMT_TIM_OFFS, fmt ^ 32'h3f, r, e);
      n = 0;
      do begin
        apb(1'b0, CONV_CTRL_OFFS, 32'h0, r, e);
        n++;
      end while (r[START_BIT] === 1'b1 && n < 4000);
      chk("start cleared", 32'h0, {31'h0, r[START_BIT]});
      chkRange("acq cycles", acqP(i[2:0]) * dv, acqP(i[2:0]) * dv, sampTot - s0);
      chkRange("conv cycles", int'(CONV_PERIODS) * dv, int'(CONV_PERIODS) * dv, convTot - c0);
      for (int f = 0; f < 2; f++) begin
        apb(1'b0, RESULT_LO_OFFS, 32'h0, r, e);
        chk("result low", expRes(v[9:0], fmt[7], 1'b0), r);
        apb(1'b0, RESULT_HI_OFFS, 32'h0, r, e);
        chk("result high", expRes(v[9:0], fmt[7], 1'b1), r);
        fmt = fmt ^ 32'h80;
        apb(1'b1, FMT_TIM_OFFS, fmt, r, e);
      end
      $display("test conversion %0d done", i);
    end
    // Reset in mid-conversion returns every register and the flag to zero
    apb(1'b1, FMT_TIM_OFFS, 32'h3f, r, e);
    apb(1'b1, REF_SEL_OFFS, 32'h5, r, e);
    apb(1'b1, CONV_CTRL_OFFS, 32'h2, r, e);
    repeat (20) @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("busy after reset", 32'h0, {31'h0, sampling | converting});
    apb(1'b0, CONV_CTRL_OFFS, 32'h0, r, e);
    chk("start after reset", 32'h0, r);
    apb(1'b0, FMT_TIM_OFFS, 32'h0, r, e);
    chk("fmt after reset", 32'h0, r);
    apb(1'b0, REF_SEL_OFFS, 32'h0, r, e);
    chk("ref after reset", 32'h0, r);
    apb(1'b0, RESULT_HI_OFFS, 32'h0, r, e);
    chk("result after reset", 32'h0, r);
    $display("test mid-run reset done");
    completeRun();
  end
endmodule : adcr_top_tb
